// ===== shared/uabc_pkg.sv
// constants, register map and state type for the auto-baud correction block
// assumes one 100 MHz clock; offsets are byte addresses on a 32-bit APB
package uabc_pkg;

   // register byte offsets
   localparam logic [7:0] UABC_OFS_CTRL = 8'h00;
   localparam logic [7:0] UABC_OFS_STATUS = 8'h04;
   localparam logic [7:0] UABC_OFS_INT_STAT = 8'h08;
   localparam logic [7:0] UABC_OFS_INT_MASK = 8'h0C;
   localparam logic [7:0] UABC_OFS_RESULT = 8'h10;
   localparam logic [7:0] UABC_OFS_SUM = 8'h14;
   localparam logic [7:0] UABC_OFS_RX_DATA = 8'h18;

   // decoded register index
   localparam logic [2:0] UABC_IDX_CTRL = 3'h0;
   localparam logic [2:0] UABC_IDX_STATUS = 3'h1;
   localparam logic [2:0] UABC_IDX_INT_STAT = 3'h2;
   localparam logic [2:0] UABC_IDX_INT_MASK = 3'h3;
   localparam logic [2:0] UABC_IDX_RESULT = 3'h4;
   localparam logic [2:0] UABC_IDX_SUM = 3'h5;
   localparam logic [2:0] UABC_IDX_RX_DATA = 3'h6;
   localparam logic [2:0] UABC_IDX_NONE = 3'h7;

   // field positions
   localparam int UABC_CTRL_ARM_BIT = 0;
   localparam int UABC_CTRL_LOW_BIT = 1;
   localparam int UABC_EV_START = 0;
   localparam int UABC_EV_CALIB = 1;
   localparam int UABC_EV_RX = 2;
   localparam int UABC_EV_TX = 3;
   localparam int UABC_EV_W = 4;

   // reset values
   localparam logic [1:0] UABC_CTRL_RST = 2'h0;
   localparam logic [3:0] UABC_MASK_RST = 4'h0;

   // calibration and traffic characters
   localparam logic [7:0] UABC_CHAR_CAL = 8'h55;
   localparam logic [7:0] UABC_CHAR_ALT = 8'hAA;

   // measurement and divider figures
   localparam logic [2:0] UABC_CAP_EVENTS = 3'h5;
   localparam logic [14:0] UABC_RATIO_LIMIT = 15'h0101;
   localparam logic [3:0] UABC_LOW_SPS_ADD = 4'h7;
   localparam logic [6:0] UABC_LOW_PRE_LAST = 7'h7F;
   localparam logic [3:0] UABC_FRAME_LAST = 4'h9;
   localparam logic [15:0] UABC_TIMER_MAX = 16'hFFFF;

   typedef enum logic [2:0] {
      UABC_OFF,
      UABC_WAIT_FALL,
      UABC_MEASURE,
      UABC_CALC,
      UABC_RUN
   } uabc_state_e;

endpackage

// ===== rtl/uabc_tx.sv
// transmit channel: sends the check character, then alternating traffic
// assumes bit_period is stable while tx_en is high
`timescale 1ns/1ps
`default_nettype none
module uabc_tx
   import uabc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tx_en,
   input wire logic [23:0] bit_period,
   output logic tx_line,
   output logic byte_done
);

   logic [23:0] cnt_ff, nxt_cnt;
   logic [3:0] bit_ff, nxt_bit;
   logic [9:0] sh_ff, nxt_sh;
   logic first_ff, nxt_first;
   logic alt_ff, nxt_alt;
   logic act_ff, nxt_act;
   logic tx_ff, nxt_tx;
   logic done_ff, nxt_done;
   logic [7:0] pick;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_first = first_ff;
      nxt_alt = alt_ff;
      nxt_act = act_ff;
      nxt_tx = tx_ff;
      nxt_done = 1'b0;
      pick = first_ff ? UABC_CHAR_CAL : (alt_ff ? UABC_CHAR_ALT : UABC_CHAR_CAL); // RULE_08
      if (!tx_en) begin
         // line idles high until the rate is loaded
         nxt_act = 1'b0;
         nxt_first = 1'b1; // RULE_16
         nxt_alt = 1'b0;
         nxt_tx = 1'b1;
      end else if (!act_ff) begin
         // 8 data bits, lsb first, no parity
         nxt_sh = {1'b1, pick, 1'b0}; // RULE_14
         nxt_act = 1'b1;
         nxt_cnt = 24'(bit_period - 24'h1);
         nxt_bit = 4'h0;
         nxt_tx = 1'b0;
      end else if (cnt_ff == 24'h0) begin
         if (bit_ff == UABC_FRAME_LAST) begin
            nxt_act = 1'b0;
            nxt_done = 1'b1;
            if (first_ff) begin
               nxt_first = 1'b0;
            end else begin
               nxt_alt = ~alt_ff; // RULE_08
            end
         end else begin
            nxt_bit = 4'(bit_ff + 4'h1);
            nxt_tx = sh_ff[nxt_bit];
            nxt_cnt = 24'(bit_period - 24'h1);
         end
      end else begin
         nxt_cnt = 24'(cnt_ff - 24'h1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 24'h0;
         bit_ff <= 4'h0;
         sh_ff <= 10'h3FF;
         first_ff <= 1'b1;
         alt_ff <= 1'b0;
         act_ff <= 1'b0;
         tx_ff <= 1'b1;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         first_ff <= nxt_first;
         alt_ff <= nxt_alt;
         act_ff <= nxt_act;
         tx_ff <= nxt_tx;
         done_ff <= nxt_done;
      end
   end

   assign tx_line = tx_ff;
   assign byte_done = done_ff;

   ////////////////////////////////////////////////////////////////////////////
   property p_check_first;
      @(posedge ref_clk) disable iff (rst)
      $rose(tx_en) |=> sh_ff == {1'b1, UABC_CHAR_CAL, 1'b0} && !tx_ff;
   endproperty
   a_check_first: assert property (p_check_first) // RULE_08
      else $error("first frame after enable is not the check character");

endmodule
`default_nettype wire

// ===== rtl/uabc_top.sv
// auto-baud correction: measures a calibration character, derives prescaler
// and divider, then runs a full-duplex link at the corrected rate
// assumes an apb master on ref_clk; rx_pin is asynchronous
//
// Functional notes
// [RULE_01] a falling edge on the receive line starts the capture timer
// [RULE_02] four rising-edge interval captures make one measurement
// [RULE_03] remote bit width and baud come from the four capture values
// [RULE_04] remote sends 55H lsb-first, or AAH msb-first
// [RULE_05] calibration character has no parity or odd parity
// [RULE_06] halve ratio, bump prescaler from zero until ratio below 257
// [RULE_07] divider field is (ratio+1)/2-1 in bits 7:1, bit 0 zero
// [RULE_08] after correction send 55H once, then 55H and AAH alternately
// [RULE_09] transmit and receive channels form one full-duplex link
// [RULE_10] receive line feeds edge detector and capture input together
// [RULE_11] first capture after timer start is discarded; four accumulated
// [RULE_12] on start bit: stop edge detect, clear sum, start timer
// [RULE_13] low range: timer at clock/128, prescaler gets plus 7
// [RULE_14] channels use 8 data bits, lsb first, no parity
// [RULE_15] sum of four intervals counts as eight remote bit periods
// [RULE_16] transmission stays off until prescaler and divider are loaded
`timescale 1ns/1ps
`default_nettype none
module uabc_top
   import uabc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   output logic transmit_line,
   output logic irq
);

   function automatic logic [2:0] uabc_decode(input logic [7:0] a);
      case (a)
         UABC_OFS_CTRL: uabc_decode = UABC_IDX_CTRL;
         UABC_OFS_STATUS: uabc_decode = UABC_IDX_STATUS;
         UABC_OFS_INT_STAT: uabc_decode = UABC_IDX_INT_STAT;
         UABC_OFS_INT_MASK: uabc_decode = UABC_IDX_INT_MASK;
         UABC_OFS_RESULT: uabc_decode = UABC_IDX_RESULT;
         UABC_OFS_SUM: uabc_decode = UABC_IDX_SUM;
         UABC_OFS_RX_DATA: uabc_decode = UABC_IDX_RX_DATA;
         default: uabc_decode = UABC_IDX_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
   logic edge_interrupt_input, capture_timer_input;
   logic fall_seen, rise_seen;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_meta_ff <= rx_pin;
         rx_sync_ff <= rx_meta_ff;
         rx_prev_ff <= rx_sync_ff;
      end
   end

   // one synchronised line drives both watchers so they never disagree
   assign edge_interrupt_input = rx_sync_ff; // RULE_10
   assign capture_timer_input = rx_sync_ff; // RULE_10
   assign fall_seen = rx_prev_ff & ~edge_interrupt_input;
   assign rise_seen = ~rx_prev_ff & capture_timer_input;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave and software state
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic [3:0] mask_ff, nxt_mask;
   logic [3:0] stat_ff, nxt_stat;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic irq_ff, nxt_irq;
   logic [3:0] ev;
   logic ev_start, ev_calib;
   logic wr_take;
   logic [2:0] idx;
   logic [31:0] rd_val;

   uabc_state_e state_ff, nxt_state;
   logic [6:0] pre_ff, nxt_pre;
   logic [15:0] timer_ff, nxt_timer;
   logic [2:0] cap_left_ff, nxt_cap_left;
   logic [17:0] sum_ff, nxt_sum;
   logic [14:0] ratio_ff, nxt_ratio;
   logic [3:0] sps_ff, nxt_sps;
   logic [7:0] div_reg_ff, nxt_div_reg;
   logic [23:0] period_ff, nxt_period;
   logic tx_en_ff, nxt_tx_en;
   logic tick;
   logic [8:0] half_up;
   logic [6:0] div7;

   logic rx_busy_ff, nxt_rx_busy;
   logic [23:0] rx_cnt_ff, nxt_rx_cnt;
   logic [3:0] rx_bit_ff, nxt_rx_bit;
   logic [7:0] rx_sh_ff, nxt_rx_sh;
   logic [7:0] rx_data_ff, nxt_rx_data;
   logic rx_ev;
   logic tx_done;

   assign idx = uabc_decode(paddr);
   assign wr_take = psel & penable & pready_ff & pwrite;

   always_comb begin
      case (idx)
         UABC_IDX_CTRL: rd_val = {30'h0, ctrl_ff};
         UABC_IDX_STATUS: rd_val = {27'h0, rx_busy_ff, tx_en_ff, 3'(state_ff)};
         UABC_IDX_INT_STAT: rd_val = {28'h0, stat_ff};
         UABC_IDX_INT_MASK: rd_val = {28'h0, mask_ff};
         UABC_IDX_RESULT: rd_val = {20'h0, sps_ff, div_reg_ff};
         UABC_IDX_SUM: rd_val = {14'h0, sum_ff};
         UABC_IDX_RX_DATA: rd_val = {24'h0, rx_data_ff};
         default: rd_val = 32'h0000_0000;
      endcase
      // one wait state: pready rises in the second access cycle
      nxt_pready = psel & penable & ~pready_ff;
      nxt_prdata = nxt_pready ? rd_val : prdata_ff;
      nxt_pslverr = nxt_pready & (idx == UABC_IDX_NONE);
      nxt_ctrl = ctrl_ff;
      nxt_mask = mask_ff;
      nxt_stat = stat_ff;
      if (wr_take && idx == UABC_IDX_CTRL) begin
         nxt_ctrl = pwdata[1:0];
      end
      if (wr_take && idx == UABC_IDX_INT_MASK) begin
         nxt_mask = pwdata[3:0];
      end
      if (wr_take && idx == UABC_IDX_INT_STAT) begin
         nxt_stat = stat_ff & ~pwdata[3:0];
      end
      // a new event beats a same-cycle clear
      nxt_stat = nxt_stat | ev;
      nxt_irq = |(nxt_stat & mask_ff);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= UABC_CTRL_RST;
         mask_ff <= UABC_MASK_RST;
         stat_ff <= 4'h0;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         mask_ff <= nxt_mask;
         stat_ff <= nxt_stat;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         irq_ff <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // measurement and rate calculation
   assign tick = ctrl_ff[UABC_CTRL_LOW_BIT] ? (pre_ff == UABC_LOW_PRE_LAST) : 1'b1; // RULE_13
   assign half_up = 9'(ratio_ff[8:0] + 9'h1) >> 1;
   assign div7 = 7'(half_up - 9'h1);

   always_comb begin
      nxt_state = state_ff;
      nxt_pre = 7'(pre_ff + 7'h1);
      nxt_timer = timer_ff;
      nxt_cap_left = cap_left_ff;
      nxt_sum = sum_ff;
      nxt_ratio = ratio_ff;
      nxt_sps = sps_ff;
      nxt_div_reg = div_reg_ff;
      nxt_period = period_ff;
      nxt_tx_en = 1'b0;
      ev_start = 1'b0;
      ev_calib = 1'b0;
      if (tick && timer_ff != UABC_TIMER_MAX) begin
         nxt_timer = 16'(timer_ff + 16'h1);
      end
      case (state_ff)
         UABC_OFF: begin
            if (ctrl_ff[UABC_CTRL_ARM_BIT]) begin
               nxt_state = UABC_WAIT_FALL;
            end
         end
         UABC_WAIT_FALL: begin
            if (fall_seen) begin
               // edge watch ends here: only MEASURE looks at edges now
               nxt_state = UABC_MEASURE; // RULE_01
               nxt_sum = 18'h0; // RULE_12
               nxt_timer = 16'h0;
               nxt_pre = 7'h0;
               nxt_cap_left = UABC_CAP_EVENTS;
               ev_start = 1'b1;
            end
         end
         UABC_MEASURE: begin
            if (rise_seen) begin
               // a tick on the capture edge already belongs to the next interval
               nxt_timer = tick ? 16'h1 : 16'h0;
               nxt_cap_left = 3'(cap_left_ff - 3'h1);
               // first capture spans start bit to first edge: dropped
               if (cap_left_ff != UABC_CAP_EVENTS) begin // RULE_11
                  nxt_sum = 18'(sum_ff + {2'h0, timer_ff}); // RULE_02
               end
               if (cap_left_ff == 3'h1) begin
                  nxt_state = UABC_CALC;
                  // four intervals of two bits each: sum/8 is one bit
                  nxt_ratio = nxt_sum[17:3]; // RULE_15 RULE_03
                  nxt_sps = ctrl_ff[UABC_CTRL_LOW_BIT] ? UABC_LOW_SPS_ADD : 4'h0; // RULE_13
               end
            end
         end
         UABC_CALC: begin
            if (ratio_ff >= UABC_RATIO_LIMIT) begin
               nxt_ratio = ratio_ff >> 1; // RULE_06
               nxt_sps = 4'(sps_ff + 4'h1);
            end else begin
               nxt_div_reg = {div7, 1'b0}; // RULE_07
               nxt_period = 24'({8'({1'b0, div7} + 8'h01), 1'b0}) << sps_ff;
               nxt_state = UABC_RUN;
               ev_calib = 1'b1;
            end
         end
         UABC_RUN: begin
            nxt_tx_en = 1'b1; // RULE_16
         end
         default: begin
            nxt_state = UABC_OFF;
         end
      endcase
      if (!ctrl_ff[UABC_CTRL_ARM_BIT]) begin
         nxt_state = UABC_OFF;
         nxt_tx_en = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= UABC_OFF;
         pre_ff <= 7'h0;
         timer_ff <= 16'h0;
         cap_left_ff <= 3'h0;
         sum_ff <= 18'h0;
         ratio_ff <= 15'h0;
         sps_ff <= 4'h0;
         div_reg_ff <= 8'h0;
         period_ff <= 24'h0;
         tx_en_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pre_ff <= nxt_pre;
         timer_ff <= nxt_timer;
         cap_left_ff <= nxt_cap_left;
         sum_ff <= nxt_sum;
         ratio_ff <= nxt_ratio;
         sps_ff <= nxt_sps;
         div_reg_ff <= nxt_div_reg;
         period_ff <= nxt_period;
         tx_en_ff <= nxt_tx_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive channel at the corrected rate; samples mid-bit
   always_comb begin
      nxt_rx_busy = rx_busy_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_data = rx_data_ff;
      rx_ev = 1'b0;
      if (!tx_en_ff) begin
         nxt_rx_busy = 1'b0;
      end else if (!rx_busy_ff) begin
         if (fall_seen) begin
            nxt_rx_busy = 1'b1; // RULE_09
            nxt_rx_cnt = period_ff >> 1;
            nxt_rx_bit = 4'h0;
         end
      end else if (rx_cnt_ff != 24'h0) begin
         nxt_rx_cnt = 24'(rx_cnt_ff - 24'h1);
      end else begin
         nxt_rx_cnt = 24'(period_ff - 24'h1);
         nxt_rx_bit = 4'(rx_bit_ff + 4'h1);
         if (rx_bit_ff == 4'h0 && rx_sync_ff) begin
            nxt_rx_busy = 1'b0;
         end else if (rx_bit_ff == UABC_FRAME_LAST) begin
            // bad stop bit drops the byte
            nxt_rx_busy = 1'b0;
            if (rx_sync_ff) begin
               nxt_rx_data = rx_sh_ff; // RULE_14
               rx_ev = 1'b1;
            end
         end else if (rx_bit_ff != 4'h0) begin
            nxt_rx_sh = {rx_sync_ff, rx_sh_ff[7:1]};
         end
      end
   end

   // packed in event-position order: start, calib, rx, tx
   assign ev = {tx_done, rx_ev, ev_calib, ev_start};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_busy_ff <= 1'b0;
         rx_cnt_ff <= 24'h0;
         rx_bit_ff <= 4'h0;
         rx_sh_ff <= 8'h0;
         rx_data_ff <= 8'h0;
      end else begin
         rx_busy_ff <= nxt_rx_busy;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_bit_ff <= nxt_rx_bit;
         rx_sh_ff <= nxt_rx_sh;
         rx_data_ff <= nxt_rx_data;
      end
   end

   uabc_tx u_tx (
      .ref_clk(ref_clk),
      .rst(rst),
      .tx_en(tx_en_ff),
      .bit_period(period_ff),
      .tx_line(transmit_line),
      .byte_done(tx_done)
   );

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_start_seen;
      state_ff == UABC_WAIT_FALL && fall_seen && ctrl_ff[UABC_CTRL_ARM_BIT];
   endsequence

   property p_start_timer;
      @(posedge ref_clk) disable iff (rst)
      s_start_seen |=> state_ff == UABC_MEASURE && sum_ff == 18'h0 && cap_left_ff == 3'h5;
   endproperty
   a_start_timer: assert property (p_start_timer) // RULE_01 RULE_12
      else $error("start bit did not arm the capture timer");

   property p_four_caps;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_MEASURE && rise_seen && cap_left_ff == 3'h1 &&
         ctrl_ff[UABC_CTRL_ARM_BIT] |=> state_ff == UABC_CALC;
   endproperty
   a_four_caps: assert property (p_four_caps) // RULE_02
      else $error("measurement did not end after the last capture");

   property p_discard_first;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_MEASURE && rise_seen && cap_left_ff == 3'h5 |=> sum_ff == 18'h0;
   endproperty
   a_discard_first: assert property (p_discard_first) // RULE_11
      else $error("first capture was accumulated");

   property p_accumulate;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_MEASURE && rise_seen && cap_left_ff < 3'h5 && cap_left_ff != 3'h0 |=>
         sum_ff == 18'($past(sum_ff) + {2'h0, $past(timer_ff)});
   endproperty
   a_accumulate: assert property (p_accumulate) // RULE_15
      else $error("capture not added to the sum");

   property p_ratio_bound;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_RUN |-> ratio_ff < 15'h0101;
   endproperty
   a_ratio_bound: assert property (p_ratio_bound) // RULE_06
      else $error("divide ratio not reduced below 257");

   property p_div_field;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_CALC && ratio_ff < 15'h0101 |=>
         div_reg_ff[0] == 1'b0 && div_reg_ff[7:1] == 7'(((9'($past(ratio_ff[8:0]) + 9'h1) >> 1) - 9'h1));
   endproperty
   a_div_field: assert property (p_div_field) // RULE_07
      else $error("divider field wrong");

   property p_tx_quiet;
      @(posedge ref_clk) disable iff (rst)
      state_ff != UABC_RUN ##1 state_ff != UABC_RUN |-> transmit_line;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) // RULE_16
      else $error("transmit line active before rate loaded");

   property p_low_sps;
      @(posedge ref_clk) disable iff (rst)
      state_ff == UABC_CALC && ctrl_ff[UABC_CTRL_LOW_BIT] |-> sps_ff >= 4'h7;
   endproperty
   a_low_sps: assert property (p_low_sps) // RULE_13
      else $error("low range prescaler lacks offset of seven");

endmodule
`default_nettype wire

// ===== tb/uabc_remote.sv
// remote serial party: sends 8N1 frames on the receive pin, decodes
// the transmit pin; assumes both ends use period clock cycles a bit
`timescale 1ns/1ps
`default_nettype none
module uabc_remote (
   input wire logic ref_clk,
   input wire logic [23:0] period,
   input wire logic send,
   input wire logic [7:0] send_byte,
   output logic rx_line,
   output logic busy,
   input wire logic tx_in,
   output logic [7:0] dec_byte,
   output logic dec_stb
);
   logic [9:0] frm;
   logic [7:0] sh;
   initial begin
      rx_line = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (send) begin
            busy <= 1'b1;
            frm = {1'b1, send_byte, 1'b0};
            for (int i = 0; i < 10; i++) begin
               rx_line <= frm[i];
               repeat (period) @(posedge ref_clk);
            end
            busy <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////
   // mid-bit sampling; a bad stop bit drops the byte
   initial begin
      dec_stb = 1'b0;
      dec_byte = 8'h00;
      forever begin
         @(posedge ref_clk);
         dec_stb <= 1'b0;
         if (tx_in === 1'b0) begin
            repeat (period / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
               repeat (period) @(posedge ref_clk);
               sh[i] = tx_in;
            end
            repeat (period) @(posedge ref_clk);
            if (tx_in === 1'b1) begin
               dec_byte <= sh;
               dec_stb <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_uabc_top.sv
// bench for the auto-baud block: calibrations from a table, then
// traffic, interrupt, error and reset cases; apb master on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tb_uabc_top
   import uabc_pkg::*;
;
   typedef struct {logic low; logic [23:0] b; logic [31:0] res; logic [31:0] sum;} uabc_row_s;
   // low range needs a bit period that is a multiple of 128 cycles
   uabc_row_s rows [5] = '{
      '{1'b1, 24'h00_0A00, 32'h0000_0712, 32'h0000_00A0},
      '{1'b0, 24'h00_0100, 32'h0000_00FE, 32'h0000_0800},
      '{1'b0, 24'h00_0101, 32'h0000_017E, 32'h0000_0808},
      '{1'b0, 24'h00_00C8, 32'h0000_00C6, 32'h0000_0640},
      '{1'b0, 24'h00_0258, 32'h0000_0294, 32'h0000_12C0}};
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rx_pin, transmit_line, irq, busy, dec_stb, er;
   logic [23:0] period = 24'h00_0100;
   logic send = 1'b0;
   logic [7:0] send_byte = 8'h00;
   logic [7:0] dec_byte;
   logic [7:0] got [$];
   int miscompares = 0, n_compared = 0, cyc = 0, n;
   uabc_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_pin(rx_pin), .transmit_line(transmit_line), .irq(irq));
   uabc_remote remote (.ref_clk(ref_clk), .period(period), .send(send),
      .send_byte(send_byte), .rx_line(rx_pin), .busy(busy), .tx_in(transmit_line),
      .dec_byte(dec_byte), .dec_stb(dec_stb));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (dec_stb === 1'b1) got.push_back(dec_byte);
      cyc++;
      if (cyc == 90000) begin
         miscompares++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////
   task summarize();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one idle cycle first, so psel is never assigned twice in a step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // answer taken at the rising edge that sees ready high; only the timeout ends a hang
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task tx_byte(input logic [7:0] v);
      int k;
      send_byte <= v;
      send <= 1'b1;
      @(posedge ref_clk);
      send <= 1'b0;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (busy !== 1'b0 && k < 40000);
   endtask
   task cal(input uabc_row_s r);
      int k;
      apb(1'b1, UABC_OFS_CTRL, 32'h0000_0000);
      period <= r.b;
      apb(1'b1, UABC_OFS_INT_STAT, 32'h0000_000F);
      apb(1'b1, UABC_OFS_CTRL, {30'h0, r.low, 1'b1});
      tx_byte(UABC_CHAR_CAL);
      k = 0;
      do begin
         apb(1'b0, UABC_OFS_STATUS, 32'h0000_0000);
         k++;
      end while (rd[2:0] !== 3'h4 && k < 100);
      got.delete();
      apb(1'b0, UABC_OFS_RESULT, 32'h0000_0000);
      chk(rd, r.res);
      apb(1'b0, UABC_OFS_SUM, 32'h0000_0000);
      chk(rd, r.sum);
      apb(1'b0, UABC_OFS_INT_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_0003, 32'h0000_0003);
   endtask
   ////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) cal(rows[i]);
      n = 0;
      while (got.size() < 3 && n < 40000) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(got[0]), 32'(UABC_CHAR_CAL));
      chk(32'(got[1]), 32'(UABC_CHAR_CAL));
      chk(32'(got[2]), 32'(UABC_CHAR_ALT));
      tx_byte(8'h3C);
      apb(1'b0, UABC_OFS_RX_DATA, 32'h0000_0000);
      chk(rd, 32'h0000_003C);
      apb(1'b1, UABC_OFS_INT_MASK, 32'h0000_0004);
      repeat (3) @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, UABC_OFS_INT_STAT, 32'h0000_0004);
      repeat (3) @(posedge ref_clk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(er), 32'h0000_0001);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'(transmit_line), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      rst <= 1'b0;
      apb(1'b0, UABC_OFS_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, UABC_OFS_INT_MASK, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, UABC_OFS_CTRL, 32'h0000_0001);
      repeat (200) @(posedge ref_clk);
      chk(32'(transmit_line), 32'h0000_0001);
      summarize();
   end
endmodule
`default_nettype wire
